// ===== src/pin_remap_pkg.sv
// Constants, field layouts and types shared by the pin remap design files
package pin_remap_pkg;

    // Sizes of the mapping tables and the bus
    localparam int NUM_IN   = 16;                   // Remappable peripheral inputs
    localparam int NUM_PINS = 16;                   // Remappable device pins
    localparam int NUM_FUNC = 15;                   // Peripheral outputs, codes 1..15
    localparam int SEL_W    = 4;                    // Selection field width
    localparam int DATA_W   = 32;                   // Bus data width
    localparam int ADDR_W   = 16;                   // Bus byte address width
    localparam int BE_W     = 4;                    // Byte enables

    // Selection field reset value and the no-function output code
    localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
    localparam logic [SEL_W-1:0] SEL_NONE  = 4'h0;
    localparam logic [SEL_W-1:0] SEL_ONE   = 4'h1;

    // Input mapping register byte offsets, in table order
    localparam logic [NUM_IN-1:0][ADDR_W-1:0] IN_OFFSET = {
        16'hFA50, 16'hFA4C, 16'hFA48, 16'hFA38,
        16'hFA34, 16'hFA30, 16'hFA2C, 16'hFA28,
        16'hFA24, 16'hFA20, 16'hFA1C, 16'hFA18,
        16'hFA10, 16'hFA0C, 16'hFA08, 16'hFA04
    };

    // Output mapping registers and the status word
    localparam logic [ADDR_W-1:0] OUT_BASE    = 16'hFB00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'hFB40;
    localparam int                WORD_SHIFT  = 2;

    // Status word bit positions
    localparam int ST_LOCK_BIT    = 0;              // Live lock level
    localparam int ST_REFUSED_BIT = 1;              // Sticky, write one to clear

    // Byte lane that holds every selection field
    localparam int SEL_LANE = 0;

    // Result of an address decode
    typedef struct packed {
        logic       hit;
        logic [3:0] idx;
    } addr_hit_type;

    // Selection tables
    typedef logic [NUM_IN-1:0][SEL_W-1:0]   in_table_type;
    typedef logic [NUM_PINS-1:0][SEL_W-1:0] out_table_type;

endpackage

// ===== src/route_if.sv
// Selection tables passed from the register file to the pin router
`timescale 1ns/1ps
interface route_if;
    import pin_remap_pkg::*;

    in_table_type  in_sel;                          // Pin chosen per peripheral input
    out_table_type out_sel;                         // Function chosen per pin

    // Register side drives the tables
    modport source (output in_sel, output out_sel);
    // Router side reads them
    modport sink   (input in_sel, input out_sel);
endinterface

// ===== src/pin_router.sv
// Pin synchroniser and the input and output selection multiplexers
`timescale 1ns/1ps
module pin_router
    import pin_remap_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                clk_en,
    route_if.sink                    rif,
    input  wire logic [NUM_PINS-1:0] pin_in,
    input  wire logic [NUM_FUNC-1:0] periph_out,
    output logic      [NUM_IN-1:0]   periph_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe
);

    // All router state
    typedef struct packed {
        logic [NUM_PINS-1:0] s1;                    // First sync stage, read by s2 only
        logic [NUM_PINS-1:0] s2;
        logic [NUM_PINS-1:0] s3;
        logic [NUM_PINS-1:0] filt;                  // Accepted pin level
        logic [NUM_IN-1:0]   pin_to_periph;
        logic [NUM_PINS-1:0] drive;
        logic [NUM_PINS-1:0] enable;
    } router_state_type;

    router_state_type st_q;                         // Registered state
    router_state_type st_d;                         // Next state

    ////////////////////////////////////////////////////////////////////////////
    // Next state: sync chain, agreement filter and both multiplexers
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // A pin change is accepted only once stages two and three agree
        st_d.filt = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.filt);
        // Each peripheral input follows the pin its field names
        for (int k = 0; k < NUM_IN; k++) begin
            st_d.pin_to_periph[k] = st_q.filt[rif.in_sel[k]];
        end
        // Each pin follows the function its field names; code zero leaves it undriven
        for (int n = 0; n < NUM_PINS; n++) begin
            if (rif.out_sel[n] == SEL_NONE) begin
                st_d.drive[n]  = 1'b0;
                st_d.enable[n] = 1'b0;
            end else begin
                st_d.drive[n]  = periph_out[rif.out_sel[n] - SEL_ONE];
                st_d.enable[n] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, frozen while the clock enable is low
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state flops
    assign periph_in = st_q.pin_to_periph;
    assign pin_out   = st_q.drive;
    assign pin_oe    = st_q.enable;

endmodule

// ===== src/peripheral_pin_remap.sv
// Remappable pin selection block: register file on the bus and pin router
//
// Functional notes
// - Input register low nibble picks the source pin
// - Output register low nibble picks driving function
// - Mapping writes accepted only while lock is clear
// - Upper bits read zero; fields reset to zero
// - One input register per input, word aligned with holes
`timescale 1ns/1ps
module peripheral_pin_remap
    import pin_remap_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                clk_en,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [DATA_W-1:0]   avs_writedata,
    input  wire logic [BE_W-1:0]     avs_byteenable,
    output logic      [DATA_W-1:0]   avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                mapping_write_lock,
    input  wire logic [NUM_PINS-1:0] pin_in,
    input  wire logic [NUM_FUNC-1:0] periph_out,
    output logic      [NUM_IN-1:0]   periph_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    // Finds which input mapping register an address names
    function automatic addr_hit_type in_decode(input logic [ADDR_W-1:0] addr);
        addr_hit_type r;
        r = '0;
        // The printed offsets leave holes, so each one is compared in turn
        for (int k = 0; k < NUM_IN; k++) begin
            if (addr == IN_OFFSET[k]) begin
                r.hit = 1'b1;
                r.idx = k[3:0];
            end
        end
        return r;
    endfunction

    // Finds which output mapping register an address names
    function automatic addr_hit_type out_decode(input logic [ADDR_W-1:0] addr);
        addr_hit_type r;
        r = '0;
        // One aligned word per pin, packed after the base
        for (int n = 0; n < NUM_PINS; n++) begin
            if (addr == OUT_BASE + ADDR_W'(n << WORD_SHIFT)) begin
                r.hit = 1'b1;
                r.idx = n[3:0];
            end
        end
        return r;
    endfunction

    // Widens a selection field to a bus word, upper bits zero
    function automatic logic [DATA_W-1:0] field_word(input logic [SEL_W-1:0] sel);
        return {{(DATA_W-SEL_W){1'b0}}, sel};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Block state

    // Everything the register file remembers lives in one struct
    typedef struct packed {
        logic                busy;                  // Drives waitrequest
        logic [DATA_W-1:0]   rdata;                 // Read data for the answer cycle
        in_table_type        in_sel;                // Input mapping fields
        out_table_type       out_sel;               // Output mapping fields
        logic                refused;               // A locked write was attempted
    } regs_state_type;

    regs_state_type st_q;                           // Registered state
    regs_state_type st_d;                           // Next state

    // Decode results for the current request
    addr_hit_type   in_hit;                         // Input table hit
    addr_hit_type   out_hit;                        // Output table hit
    logic           status_hit;                     // Status word hit
    logic           request;                        // Read or write pending
    logic           lane_ok;                        // Low byte lane enabled
    logic [DATA_W-1:0] read_value;                  // Word for the addressed register

    // Tables handed to the router
    route_if rif ();

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and read multiplexer
    always_comb begin
        in_hit     = in_decode(avs_address);
        out_hit    = out_decode(avs_address);
        status_hit = (avs_address == STATUS_ADDR);
        request    = avs_read | avs_write;
        lane_ok    = avs_byteenable[SEL_LANE];
        read_value = '0;
        if (in_hit.hit) begin
            // Upper bits are not stored and read back as zero
            read_value = field_word(st_q.in_sel[in_hit.idx]);
        end else if (out_hit.hit) begin
            read_value = field_word(st_q.out_sel[out_hit.idx]);
        end else if (status_hit) begin
            read_value[ST_LOCK_BIT]    = mapping_write_lock;
            read_value[ST_REFUSED_BIT] = st_q.refused;
        end
        // Unmapped addresses read as zero
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state: bus handshake, register writes and the refused flag
    //
    // Every access takes two cycles. The first edge that sees a request
    // loads the read data and drops waitrequest; the second edge is the one
    // at which the master samples waitrequest low, so the write commits
    // there and waitrequest rises again. The extra cycle keeps both bus
    // outputs straight from flops at the cost of half the peak throughput,
    // which configuration traffic never needs.
    always_comb begin
        st_d = st_q;
        if (request && st_q.busy) begin
            // First edge of an access: prepare the answer
            st_d.busy  = 1'b0;
            st_d.rdata = read_value;
        end else if (request) begin
            // Answer edge: the master completes the access here
            st_d.busy = 1'b1;
            if (avs_write && lane_ok) begin
                if (status_hit && avs_writedata[ST_REFUSED_BIT]) begin
                    // Software clears the sticky flag by writing one
                    st_d.refused = 1'b0;
                end
                if (in_hit.hit || out_hit.hit) begin
                    if (mapping_write_lock) begin
                        // Stored value stays; the attempt is recorded instead
                        st_d.refused = 1'b1;
                    end else if (in_hit.hit) begin
                        // Only the low field is kept, the rest is dropped
                        st_d.in_sel[in_hit.idx] = avs_writedata[SEL_W-1:0];
                    end else begin
                        st_d.out_sel[out_hit.idx] = avs_writedata[SEL_W-1:0];
                    end
                end
            end
        end else begin
            // Idle: waitrequest stands high until the next request
            st_d.busy = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, frozen while the clock enable is low
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q.busy    <= 1'b1;
            st_q.rdata   <= '0;
            st_q.in_sel  <= {NUM_IN{SEL_RESET}};
            st_q.out_sel <= {NUM_PINS{SEL_RESET}};
            st_q.refused <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // Bus outputs straight from the state flops
    assign avs_waitrequest = st_q.busy;
    assign avs_readdata    = st_q.rdata;

    // Tables to the router
    assign rif.in_sel  = st_q.in_sel;
    assign rif.out_sel = st_q.out_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and selection multiplexers
    pin_router u_router (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .clk_en     (clk_en),
        .rif        (rif),
        .pin_in     (pin_in),
        .periph_out (periph_out),
        .periph_in  (periph_in),
        .pin_out    (pin_out),
        .pin_oe     (pin_oe)
    );

endmodule

// ===== bench/pin_remap_sva.sv
// Concurrent checks on the remap block bus handshake and pin outputs
`timescale 1ns/1ps
module pin_remap_sva
    import pin_remap_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                rstn,
    input wire logic [ADDR_W-1:0]   avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [DATA_W-1:0]   avs_writedata,
    input wire logic [BE_W-1:0]     avs_byteenable,
    input wire logic [DATA_W-1:0]   avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic                mapping_write_lock,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe
);
    logic pin0_commit;                              // Unlocked lane 0 write to pin 0 commits
    assign pin0_commit = avs_write && !avs_waitrequest && avs_byteenable[0]
                         && !mapping_write_lock && avs_address == OUT_BASE;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered after one wait cycle");
    a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer lasted more than one cycle");
    a_locked_no_change: assert property (avs_write && !avs_waitrequest && mapping_write_lock
        |=> ##1 $stable(pin_oe)) else $error("locked write changed pin enables");
    a_pin0_set: assert property (pin0_commit && avs_writedata[3:0] != 4'h0
        |=> ##1 pin_oe[0]) else $error("pin 0 not driven after function write");
    a_pin0_clear: assert property (pin0_commit && avs_writedata[3:0] == 4'h0
        |=> ##1 !pin_oe[0]) else $error("pin 0 still driven after clearing");
    a_upper_zero: assert property (avs_read && !avs_waitrequest && avs_address != STATUS_ADDR
        |-> avs_readdata[31:4] == 28'h0) else $error("upper mapping bits not zero");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 16'hFA14
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_off_pins_low: assert property ((pin_out & ~pin_oe) == 16'h0)
        else $error("undriven pin shows a high level");
endmodule
bind peripheral_pin_remap pin_remap_sva u_sva (.core_clk(core_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mapping_write_lock(mapping_write_lock), .pin_out(pin_out), .pin_oe(pin_oe));

// ===== bench/pin_side_model.sv
// Stand-in for the peripheral outputs and the physical pins around the remap block
`timescale 1ns/1ps
module pin_side_model
    import pin_remap_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                hold,
    output logic      [NUM_PINS-1:0] pin_in,
    output logic      [NUM_FUNC-1:0] periph_out
);
    // Patterns move every cycle unless frozen, so a stale route cannot pass unseen
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_in     <= 16'hA5C3;
            periph_out <= 15'h2D71;
        end else if (!hold) begin
            pin_in     <= {pin_in[14:0], pin_in[15] ^ pin_in[13]};
            periph_out <= periph_out + 15'h1357;
        end
    end
endmodule

// ===== bench/tb.sv
// Self-checking bench for the pin remap block against a register-level reference
`timescale 1ns/1ps
module tb
    import pin_remap_pkg::*;
;
    logic                core_clk = 1'b0;
    logic                rstn = 1'b0;
    logic [ADDR_W-1:0]   avs_address = 16'h0;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [DATA_W-1:0]   avs_writedata = 32'h0;
    logic [BE_W-1:0]     avs_byteenable = 4'hF;
    logic [DATA_W-1:0]   avs_readdata;
    logic                avs_waitrequest;
    logic                mapping_write_lock = 1'b0;
    logic                hold = 1'b0;           // Freezes the pin side for route checks
    logic                clk_en = 1'b1;         // Block clock enable, dropped once to test freezing
    logic [NUM_PINS-1:0] pin_in;
    logic [NUM_FUNC-1:0] periph_out;
    logic [NUM_IN-1:0]   periph_in;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
    logic [DATA_W-1:0]   rs = 32'h32;           // Random state
    logic [DATA_W-1:0]   q;                     // Last read data
    logic [NUM_PINS-1:0] e_out;
    logic [NUM_PINS-1:0] e_oe;
    logic [NUM_IN-1:0]   e_in;
    int                  in_m[NUM_IN];          // Reference input selections
    int                  out_m[NUM_PINS];       // Reference output codes
    int                  fail_count = 0;
    int                  n_checks = 0;
    always #2 core_clk = ~core_clk;
    peripheral_pin_remap uut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mapping_write_lock(mapping_write_lock), .pin_in(pin_in), .periph_out(periph_out),
        .periph_in(periph_in), .pin_out(pin_out), .pin_oe(pin_oe));
    pin_side_model side (.core_clk(core_clk), .rstn(rstn), .hold(hold), .pin_in(pin_in),
        .periph_out(periph_out));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [DATA_W-1:0] xs(input logic [DATA_W-1:0] x);
        logic [DATA_W-1:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic summarize();
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // One access; held until waitrequest is seen low, failing the run if no answer comes within 20 cycles
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
        int n;
        @(posedge core_clk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n == 20) begin
            fail_count++;
            summarize();
        end
    endtask
    // Routes and readback against the reference tables
    task automatic verify();
        hold <= 1'b1;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < NUM_IN; i++) begin
            e_in[i]  = pin_in[in_m[i]];
            e_oe[i]  = out_m[i] != 0;
            e_out[i] = (out_m[i] != 0) ? periph_out[out_m[i] - 1] : 1'b0;
        end
        chk("periph_in", 32'(e_in), 32'(periph_in));
        chk("pin_oe", 32'(e_oe), 32'(pin_oe));
        chk("pin_out", 32'(e_out), 32'(pin_out));
        hold <= 1'b0;
        for (int i = 0; i < NUM_IN; i++) begin
            bus(1'b0, IN_OFFSET[i], 32'h0, 4'hF);
            chk("in_select", 32'(in_m[i]), q);
            bus(1'b0, OUT_BASE + 16'(i * 4), 32'h0, 4'hF);
            chk("out_select", 32'(out_m[i]), q);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        summarize();
    end
    // Main sequence: reset values, random mapping, boundary codes, then locked writes
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        verify();
        bus(1'b0, 16'hFA14, 32'h0, 4'hF);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < NUM_IN; i++) begin
            rs = xs(rs);
            bus(1'b1, IN_OFFSET[i], rs, 4'hF);
            in_m[i] = rs[3:0];
            rs = xs(rs);
            bus(1'b1, OUT_BASE + 16'(i * 4), rs, 4'hF);
            out_m[i] = rs[3:0];
        end
        bus(1'b1, IN_OFFSET[15], 32'hFFFFFFFF, 4'hF);
        in_m[15] = 15;
        bus(1'b1, OUT_BASE, 32'h0, 4'hF);
        out_m[0] = 0;
        bus(1'b1, OUT_BASE + 16'h4, 32'hF, 4'hF);
        out_m[1] = 15;
        bus(1'b1, IN_OFFSET[0], 32'h5, 4'hE);
        verify();
        mapping_write_lock <= 1'b1;
        for (int i = 0; i < NUM_IN; i++) begin
            bus(1'b1, IN_OFFSET[i], 32'(in_m[i] ^ 1), 4'hF);
            bus(1'b1, OUT_BASE + 16'(i * 4), 32'(out_m[i] ^ 3), 4'hF);
        end
        verify();
        bus(1'b0, STATUS_ADDR, 32'h0, 4'hF);
        chk("status_locked", 32'h3, q);
        mapping_write_lock <= 1'b0;
        bus(1'b1, STATUS_ADDR, 32'h2, 4'hF);
        bus(1'b0, STATUS_ADDR, 32'h0, 4'hF);
        chk("status_clear", 32'h0, q);
        // Clock enable low must freeze the outputs while the pin side keeps moving
        clk_en <= 1'b0;
        @(posedge core_clk);
        e_out = pin_out;
        e_in  = periph_in;
        repeat (4) @(posedge core_clk);
        chk("frozen_pin_out", 32'(e_out), 32'(pin_out));
        chk("frozen_periph_in", 32'(e_in), 32'(periph_in));
        clk_en <= 1'b1;
        summarize();
    end
endmodule
